/* File: hw/pilc_defines.svh */
// Constants for the priority interrupt level control block.
// Assumes inclusion by the package and the design module only.
`ifndef PILC_DEFINES_SVH
`define PILC_DEFINES_SVH
`define PILC_NLEV          128
`define PILC_LVL_HI        6
`define PILC_LVL_LO        12
`define PILC_PRIV_BIT      0
`define PILC_RSV_FIRST     7'h02
`define PILC_RSV_LAST      7'h11
`define PILC_EXT_FIRST     7'h2d
`define PILC_EXT_LAST      7'h77
`define PILC_EXT_VEC_BASE  12'h1b4
`define PILC_APU_FIRST     7'h78
`define PILC_APU_LAST      7'h7d
`define PILC_VEC_STRIDE    12'h004
`define PILC_OP_REQUEST    16'hfc02
`define PILC_OP_DEACTIVATE 16'hfc04
`endif

/* File: hw/pilc_pkg.sv */
// Types for the priority interrupt level control block.
// Assumes the defines header sits beside it.
`include "pilc_defines.svh"
package pilc_pkg;
	typedef enum logic [2:0] {
		PILC_OP_NONE,
		PILC_OP_ENABLE,
		PILC_OP_DISABLE,
		PILC_OP_REQUEST,
		PILC_OP_ACTIVATE,
		PILC_OP_DEACTIVATE
	} pilc_op_t;
	typedef logic [6:0] pilc_level_t;
endpackage : pilc_pkg

/* File: hw/pilc_level_ctrl.sv */
// Priority interrupt level state: enable, request and active per level,
// with blocking below active levels and a vector for the chosen level.
// Assumes the processor decodes the opcode and presents one op per cycle.
`include "pilc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module pilc_level_ctrl
	import pilc_pkg::*;
(
	input  wire logic         core_clk_i,
	input  wire logic         resetn_i,
	input  wire logic         op_valid_i,
	input  wire pilc_op_t     op_code_i,
	input  wire logic [31:0]  instruction_word_i,
	input  wire logic [31:0]  program_status_word_reg_i,
	input  wire logic         status_doubleword_mode_i,
	input  wire logic         clock_interrupt_module_jumper_i,
	input  wire logic [127:0] ext_class_level_i,
	input  wire logic [127:0] trap_level_i,
	input  wire logic [127:0] irq_i,
	input  wire logic         service_ack_i,
	input  wire logic         next_insn_done_i,
	output logic              priv_trap_o,
	output logic              cc_hold_o,
	output logic              uninterruptible_o,
	output logic              service_valid_o,
	output logic [6:0]        service_level_o,
	output logic [11:0]       vector_location_o,
	output logic [127:0]      enable_o,
	output logic [127:0]      request_o,
	output logic [127:0]      active_o
);

	// Vector for a level; the external range is offset from its base, other levels get four times the level
	function automatic logic [11:0] pilc_vec(input logic [6:0] lv);
		logic [11:0] off;
		off = {5'h00, lv - `PILC_EXT_FIRST};
		if (lv >= `PILC_EXT_FIRST && lv <= `PILC_EXT_LAST)
			pilc_vec = `PILC_EXT_VEC_BASE + (off << 2);
		else
			pilc_vec = {3'h0, lv, 2'h0};
	endfunction : pilc_vec

	logic [127:0] enable_r, enable_nxt;
	logic [127:0] request_r, request_nxt;
	logic [127:0] active_r, active_nxt;
	logic         priv_trap_r;
	logic         unint_r;
	logic         svc_valid_r;
	logic [6:0]   svc_level_r;
	logic [11:0]  vec_r;

	// Instruction decode and target filtering
	wire pilc_level_t lvl = instruction_word_i[31-`PILC_LVL_HI -: 7];
	wire privileged = program_status_word_reg_i[31-`PILC_PRIV_BIT];
	wire is_op      = op_valid_i && (op_code_i != PILC_OP_NONE);
	wire reserved   = (lvl >= `PILC_RSV_FIRST) && (lvl <= `PILC_RSV_LAST);
	wire ext_class  = ext_class_level_i[lvl];
	wire do_op      = is_op && privileged && !reserved && !ext_class;
	wire [127:0] sel = 128'h1 << lvl;

	// Attached-unit trap levels count as traps whatever the trap map says
	logic [127:0] apu_mask;
	always_comb begin
		for (int i = 0; i < 128; i++) begin
			apu_mask[i] = (7'(i) >= `PILC_APU_FIRST)
				&& (7'(i) <= `PILC_APU_LAST);
		end
	end

	// Forced enables: jumper for 0/1, trap levels in doubleword mode.
	// Forced bits are never stored, so leaving doubleword mode brings
	// back the software enables that were set before.
	wire [127:0] trap_all = trap_level_i | apu_mask;
	wire [127:0] force_en = (trap_all & {128{status_doubleword_mode_i}})
		| {126'h0, {2{clock_interrupt_module_jumper_i}}};
	wire [127:0] eff_en = enable_r | force_en;

	// Blocking mask: a level is blocked if it or any lower-numbered level is active
	logic [127:0] blocked;
	always_comb begin
		blocked[0] = active_r[0];
		for (int i = 1; i < 128; i++) begin
			blocked[i] = blocked[i-1] | active_r[i];
		end
	end

	wire [127:0] eligible = eff_en & request_r & ~blocked;

	// Lowest-numbered eligible level wins
	logic       pick_any;
	logic [6:0] pick_lvl;
	always_comb begin
		pick_any = 1'b0;
		pick_lvl = 7'h00;
		for (int i = 127; i >= 0; i--) begin
			if (eligible[i]) begin
				pick_any = 1'b1;
				pick_lvl = 7'(i);
			end
		end
	end

	// Next state for the three per-level vectors
	// The registered pick is one cycle old; an op in that cycle may have
	// blocked or disabled it, so valid is withdrawn until it is fresh
	wire svc_live = svc_valid_r && eligible[svc_level_r];
	wire svc_take = svc_live && service_ack_i;
	wire [127:0] svc_sel = 128'h1 << svc_level_r;
	always_comb begin
		enable_nxt  = enable_r;
		request_nxt = request_r;
		active_nxt  = active_r;
		if (svc_take) begin
			request_nxt = request_nxt & ~svc_sel;
			active_nxt  = active_nxt | svc_sel;
		end
		if (do_op) begin
			unique case (op_code_i)
				PILC_OP_ENABLE:  enable_nxt = enable_nxt | sel;
				PILC_OP_DISABLE: begin
					enable_nxt  = enable_nxt & ~sel;
					request_nxt = request_nxt & ~sel;
				end
				PILC_OP_REQUEST:    request_nxt = request_nxt | sel;
				PILC_OP_ACTIVATE:   active_nxt = active_nxt | sel;
				PILC_OP_DEACTIVATE: active_nxt = active_nxt & ~sel;
				default: ;
			endcase
		end
		// Wired sources latch only into responding levels, even when blocked
		request_nxt = request_nxt | (irq_i & eff_en);
	end

	// State registers
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			enable_r  <= '0;
			request_r <= '0;
			active_r  <= '0;
		end else begin
			enable_r  <= enable_nxt;
			request_r <= request_nxt;
			active_r  <= active_nxt;
		end
	end

	// A deactivate in doubleword mode opens the uninterruptible pair
	wire pair_start = do_op && (op_code_i == PILC_OP_DEACTIVATE)
		&& status_doubleword_mode_i;

	// Trap, pairing flag and registered service outputs
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			priv_trap_r <= 1'b0;
			unint_r     <= 1'b0;
			svc_valid_r <= 1'b0;
			svc_level_r <= 7'h00;
			vec_r       <= 12'h000;
		end else begin
			priv_trap_r <= is_op && !privileged;
			if (pair_start)
				unint_r <= 1'b1;
			else if (next_insn_done_i)
				unint_r <= 1'b0;
			// Service held off while the pair runs, from the cycle right
			// after the deactivate; the set wins over a same-cycle clear
			svc_valid_r <= pick_any && !svc_take
				&& !unint_r && !pair_start;
			svc_level_r <= pick_lvl;
			vec_r       <= pilc_vec(pick_lvl);
		end
	end

	assign priv_trap_o       = priv_trap_r;
	assign cc_hold_o         = 1'b1;
	assign uninterruptible_o = unint_r;
	assign service_valid_o   = svc_live;
	assign service_level_o   = svc_level_r;
	assign vector_location_o = vec_r;
	assign enable_o          = eff_en;
	assign request_o         = request_r;
	assign active_o          = active_r;

	// Checks
	property p_priv;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(is_op && !privileged) |=> priv_trap_o;
	endproperty
	a_priv: assert property (p_priv) else $error("no priv trap");

	property p_rsv;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(is_op && reserved && !svc_take)
		|=> $stable(enable_r) && $stable(active_r);
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved op acted");

	property p_req;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(do_op && op_code_i == PILC_OP_REQUEST)
		|=> request_r[$past(lvl)];
	endproperty
	a_req: assert property (p_req) else $error("request not stored");

	property p_act;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(do_op && op_code_i == PILC_OP_ACTIVATE) |=> active_r[$past(lvl)];
	endproperty
	a_act: assert property (p_act) else $error("active not set");

	property p_dis;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(do_op && op_code_i == PILC_OP_DISABLE && !svc_take)
		|=> !enable_r[$past(lvl)] && (active_r == $past(active_r));
	endproperty
	a_dis: assert property (p_dis) else $error("disable wrong");

	property p_dea;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(do_op && op_code_i == PILC_OP_DEACTIVATE && !svc_take)
		|=> !active_r[$past(lvl)] && ((request_r & $past(request_r))
		== $past(request_r));
	endproperty
	a_dea: assert property (p_dea) else $error("deactivate wrong");

	property p_block;
		@(posedge core_clk_i) disable iff (!resetn_i)
		service_valid_o
		|-> !(|($past(blocked) & (128'h1 << service_level_o)));
	endproperty
	a_block: assert property (p_block) else $error("blocked served");

	property p_pair;
		@(posedge core_clk_i) disable iff (!resetn_i)
		uninterruptible_o |-> !service_valid_o ##1 !service_valid_o;
	endproperty
	a_pair: assert property (p_pair) else $error("pair interrupted");

	property p_ext;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(is_op && ext_class && !svc_take)
		|=> $stable(enable_r) && $stable(active_r);
	endproperty
	a_ext: assert property (p_ext) else $error("class op acted");

	property p_en;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(do_op && op_code_i == PILC_OP_ENABLE) |=> enable_o[$past(lvl)];
	endproperty
	a_en: assert property (p_en) else $error("enable not set");

	property p_clr;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(do_op && op_code_i == PILC_OP_DISABLE && !irq_i[lvl])
		|=> !request_r[$past(lvl)];
	endproperty
	a_clr: assert property (p_clr) else $error("request kept");

	property p_force;
		@(posedge core_clk_i) disable iff (!resetn_i)
		status_doubleword_mode_i
		|-> ((enable_o & trap_level_i) == trap_level_i);
	endproperty
	a_force: assert property (p_force) else $error("trap disabled");

	property p_jmp;
		@(posedge core_clk_i) disable iff (!resetn_i)
		clock_interrupt_module_jumper_i |-> (enable_o[1:0] == 2'h3);
	endproperty
	a_jmp: assert property (p_jmp) else $error("jumper ignored");

	// Requests latch even while blocked, so they are served later
	property p_store;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(|(irq_i & eff_en))
		|=> ((request_r & $past(irq_i & eff_en)) == $past(irq_i & eff_en));
	endproperty
	a_store: assert property (p_store) else $error("request lost");

	// No eligible level numbered below the presented one
	property p_win;
		@(posedge core_clk_i) disable iff (!resetn_i)
		service_valid_o
		|-> !(|($past(eligible) & ((128'h1 << service_level_o) - 128'h1)));
	endproperty
	a_win: assert property (p_win) else $error("wrong level won");

	property p_pulse;
		@(posedge core_clk_i) disable iff (!resetn_i)
		!(is_op && !privileged) |=> !priv_trap_o;
	endproperty
	a_pulse: assert property (p_pulse) else $error("stray trap");

	c_serve: cover property (@(posedge core_clk_i)
		service_valid_o && service_ack_i);
	c_trap:  cover property (@(posedge core_clk_i) priv_trap_o);
	c_pair:  cover property (@(posedge core_clk_i) uninterruptible_o);
	c_held:  cover property (@(posedge core_clk_i)
		|(request_r & eff_en & blocked));
	c_force: cover property (@(posedge core_clk_i)
		|(force_en & ~enable_r));

endmodule : pilc_level_ctrl
`default_nettype wire

/* File: test/pilc_cpu_model.sv */
// Processor model: issues level-control ops and service acks.
// Assumes a free-running clock; after the idle values at time zero it drives only on falling edges.
`timescale 1ns/1ps
`default_nettype none
module pilc_cpu_model
	import pilc_pkg::*;
(
	input  wire logic   core_clk_i,
	output var pilc_op_t op_code_o,
	output logic        op_valid_o,
	output logic [31:0] iw_o,
	output logic [31:0] psw_o,
	output logic        ack_o
);
	// Idle after power-up
	initial begin
		op_valid_o = 1'b0;
		op_code_o = PILC_OP_NONE;
		iw_o = 32'h0000_0000;
		psw_o = 32'h8000_0000;
		ack_o = 1'b0;
	end

	// One op held over one rising edge; the word is inverted on release
	// so that a stale level field cannot be mistaken for a live one
	task automatic issue(input pilc_op_t op, input logic [6:0] lvl,
			input logic priv);
		@(negedge core_clk_i);
		op_valid_o = 1'b1;
		op_code_o = op;
		iw_o = {6'h3f, lvl, 19'h7ffff};
		psw_o = {priv, 31'h7fffffff};
		@(negedge core_clk_i);
		op_valid_o = 1'b0;
		op_code_o = PILC_OP_NONE;
		iw_o = ~iw_o;
	endtask : issue

	// Take the presented level, one cycle pulse
	task automatic ack();
		@(negedge core_clk_i);
		ack_o = 1'b1;
		@(negedge core_clk_i);
		ack_o = 1'b0;
	endtask : ack
endmodule : pilc_cpu_model
`default_nettype wire

/* File: test/tb_priority_interrupt_level_control.sv */
// Testbench for the level control block with a processor model.
// Assumes the package and design file are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_priority_interrupt_level_control;
	import pilc_pkg::*;
	logic clk, resetn, sdw, jmp, nid, trap_o, cc, unint, sv;
	logic [127:0] ext, trap, irq, en, rq, act;
	logic [6:0] lvl;
	logic [11:0] vec;
	pilc_op_t code;
	logic valid, ack;
	logic [31:0] iw, psw;
	int n_mismatch, compares, cycles;

	pilc_cpu_model cpu(.core_clk_i(clk), .op_code_o(code),
		.op_valid_o(valid), .iw_o(iw), .psw_o(psw), .ack_o(ack));
	pilc_level_ctrl pilc_level_ctrl_inst(.core_clk_i(clk),
		.resetn_i(resetn), .op_valid_i(valid), .op_code_i(code),
		.instruction_word_i(iw), .program_status_word_reg_i(psw),
		.status_doubleword_mode_i(sdw),
		.clock_interrupt_module_jumper_i(jmp),
		.ext_class_level_i(ext), .trap_level_i(trap), .irq_i(irq),
		.service_ack_i(ack), .next_insn_done_i(nid),
		.priv_trap_o(trap_o), .cc_hold_o(cc), .uninterruptible_o(unint),
		.service_valid_o(sv), .service_level_o(lvl),
		.vector_location_o(vec), .enable_o(en), .request_o(rq),
		.active_o(act));

	// Free-running 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Hang guard, far above the fifty or so cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			complete_run();
		end
	end

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic op(input pilc_op_t c, input logic [6:0] l);
		cpu.issue(c, l, 1'b1);
	endtask : op

	task automatic complete_run();
		$display("checks %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run

	// Main sequence; state is read at the falling edge after each op
	initial begin
		resetn = 1'b0;
		{sdw, jmp, nid} = 3'h0;
		{ext, trap, irq} = '0;
		repeat (5) @(negedge clk); // Five rising edges in reset
		resetn = 1'b1;
		chk({sv, cc, |en, |rq, |act}, 12'h008);
		op(PILC_OP_REQUEST, 7'h30);
		chk(rq[48], 1'b1);
		op(PILC_OP_ENABLE, 7'h30);
		chk(en[48], 1'b1);
		@(negedge clk);
		chk({sv, 4'h0, lvl}, 12'h830);
		chk(vec, 12'h1c0);
		cpu.ack();
		chk({act[48], rq[48]}, 12'h002);
		op(PILC_OP_ENABLE, 7'h40);
		irq[64] = 1'b1;
		@(negedge clk);
		irq[64] = 1'b0;
		@(negedge clk);
		chk({rq[64], sv}, 12'h002);
		op(PILC_OP_ACTIVATE, 7'h20);
		chk({act[32], en[32]}, 12'h002);
		op(PILC_OP_DEACTIVATE, 7'h30);
		@(negedge clk);
		chk({act[48], rq[64], sv}, 12'h002);
		op(PILC_OP_DEACTIVATE, 7'h20);
		@(negedge clk);
		chk({sv, 4'h0, lvl}, 12'h840);
		chk(vec, 12'h200);
		op(PILC_OP_REQUEST, 7'h31);
		op(PILC_OP_ENABLE, 7'h31);
		@(negedge clk);
		chk({sv, 4'h0, lvl}, 12'h831);
		op(PILC_OP_ACTIVATE, 7'h31);
		op(PILC_OP_DISABLE, 7'h31);
		chk({act[49], rq[49], en[49]}, 12'h004);
		ext[96] = 1'b1;
		op(PILC_OP_ENABLE, 7'h60);
		op(PILC_OP_ENABLE, 7'h05);
		op(PILC_OP_REQUEST, 7'h11);
		op(PILC_OP_ENABLE, 7'h12);
		chk({en[96], en[5], rq[17], en[18]}, 12'h001);
		cpu.issue(PILC_OP_ENABLE, 7'h70, 1'b0);
		chk({trap_o, en[112]}, 12'h002);
		sdw = 1'b1;
		trap[122] = 1'b1;
		op(PILC_OP_DISABLE, 7'h7a);
		chk(en[122], 1'b1);
		op(PILC_OP_DEACTIVATE, 7'h12);
		chk(unint, 1'b1);
		nid = 1'b1;
		@(negedge clk);
		nid = 1'b0;
		jmp = 1'b1;
		@(negedge clk);
		chk({unint, en[1:0]}, 12'h003);
		complete_run();
	end
endmodule : tb_priority_interrupt_level_control
`default_nettype wire
